// [dbgp_tap_port.sv]
// debug test access port: tap controller, debug chains, apb registers
//
// How it works
// [R1] four pins tms, tck, tdi, tdo; no test reset pin.
// [R2] enable fuse unprogrammed: pins are general purpose, tap held in reset.
// [R3] fuse programmed, disable bit clear: pull tap inputs high, port on.
// [R4] tdo is not driven outside the shift states.
// [R5] sixteen-state controller stepped by tms at each rising tck edge.
// [R6] after power-on reset the controller sits in test-logic-reset.
// [R7] every shift register moves its lsb in and out first.
// [R8] controller drives tms 1,1,0,0 from idle to reach shift-ir.
// [R9] 4-bit instruction; msb taken on the edge that leaves shift-ir.
// [R10] while shifting the instruction, tdo gives captured value 0x01.
// [R11] instruction latched in update-ir, then selects the data register.
// [R12] controller drives tms 1,0,0 from idle to reach shift-dr.
// [R13] data shift outputs the values captured in capture-dr.
// [R14] latched data register outputs change only in update-dr; the halt bit also clears whenever debug is not allowed.
// [R15] five tck periods of tms high always reach test-logic-reset.
// [R16] cpu instruction executes in idle; idle not needed before data scan.
// [R17] cpu runs scanned instructions; results come back through comm byte.
// [R18] flow, step, two program and two combined breakpoints, range option.
// [R19] debug works only with both fuses programmed and no lock bit; a break flag set earlier stays set, holding cpu_halt_req and break_hit high.
// [R20] codes 8 to B are the private debug instructions.
// [R21] debugger watches and may pull the open-collector reset line; this port has no reset line pin.
// [R22] tdo changes on the falling tck edge.
`include "dbgp_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module dbgp_tap_port
	import dbgp_pkg::*;
#(
	parameter int INSN_W = 16
)
(
	input  wire logic                  pclk,
	input  wire logic                  presetn,
	input  wire logic                  psel,
	input  wire logic                  penable,
	input  wire logic                  pwrite,
	input  wire logic [7:0]            paddr,
	input  wire logic [31:0]           pwdata,
	output var  logic [31:0]           prdata,
	output var  logic                  pready,
	output var  logic                  pslverr,
	input  wire logic                  tck_pin,
	input  wire logic                  tms_pin,
	input  wire logic                  tdi_pin,
	output var  logic                  tdo_o,
	output var  logic                  tdo_oe,
	output var  logic                  tap_pullup_en,
	output var  logic                  tap_pins_gpio,
	input  wire logic                  debug_port_enable_fuse,
	input  wire logic                  onchip_debug_enable_fuse,
	input  wire logic                  lock_bit_set,
	input  wire dbgp_pkg::dbgp_cpu_obs_t cpu_obs,
	output var  logic [INSN_W-1:0]     cpu_insn,
	output var  logic                  cpu_insn_valid,
	output var  logic                  cpu_halt_req,
	output var  logic                  break_hit
);
	import dbgp_pkg::*;

	// only the 16-bit cpu chain is built
	if (INSN_W != `DBGP_LEN_CPU)
	begin : g_insn_w_check
		$error("cpu instruction chain must be 16 bits");
	end

	// ----------------------------------------------------------------
	// pin synchronisers and tck edges
	// ----------------------------------------------------------------
	logic [5:0] sync1_reg;
	logic [5:0] sync2_reg;
	logic       tck_prev_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync1_reg <= 6'h00;
			sync2_reg <= 6'h00;
			tck_prev_reg <= 1'h0;
		end
		else
		begin
			sync1_reg <= {lock_bit_set, onchip_debug_enable_fuse,
				debug_port_enable_fuse, tdi_pin, tms_pin, tck_pin};
			sync2_reg <= sync1_reg;
			tck_prev_reg <= sync2_reg[0];
		end
	end

	logic tck_s, tms_s, tdi_s, tck_rise, tck_fall;
	logic port_en, debug_ok, ctrl_disable_reg;
	assign tck_s    = sync2_reg[0];
	assign tms_s    = sync2_reg[1];
	assign tdi_s    = sync2_reg[2];
	assign tck_rise = tck_s & ~tck_prev_reg;
	assign tck_fall = ~tck_s & tck_prev_reg;
	assign port_en  = sync2_reg[3] & ~ctrl_disable_reg; // [R2] [R3]
	assign debug_ok = port_en & sync2_reg[4] & ~sync2_reg[5]; // [R19]

	// ----------------------------------------------------------------
	// tap controller
	// ----------------------------------------------------------------
	function automatic dbgp_state_t next_state(dbgp_state_t s, logic m);
		case (s)
			ST_RESET:    next_state = m ? ST_RESET    : ST_IDLE;
			ST_IDLE:     next_state = m ? ST_SEL_DR   : ST_IDLE;
			ST_SEL_DR:   next_state = m ? ST_SEL_IR   : ST_CAP_DR;
			ST_CAP_DR:   next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: next_state = m ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: next_state = m ? ST_UPD_DR   : ST_PAUSE_DR;
			ST_PAUSE_DR: next_state = m ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: next_state = m ? ST_UPD_DR   : ST_SHIFT_DR;
			ST_UPD_DR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
			ST_SEL_IR:   next_state = m ? ST_RESET    : ST_CAP_IR;
			ST_CAP_IR:   next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: next_state = m ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: next_state = m ? ST_UPD_IR   : ST_PAUSE_IR;
			ST_PAUSE_IR: next_state = m ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: next_state = m ? ST_UPD_IR   : ST_SHIFT_IR;
			ST_UPD_IR:   next_state = m ? ST_SEL_DR   : ST_IDLE;
			default:     next_state = ST_RESET;
		endcase
	endfunction

	dbgp_state_t state_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_reg <= ST_RESET; // [R6]
		else if (!port_en)
			state_reg <= ST_RESET; // [R2]
		else if (tck_rise)
			state_reg <= next_state(state_reg, tms_s); // [R5] [R15]
	end

	// ----------------------------------------------------------------
	// instruction register
	// ----------------------------------------------------------------
	logic [3:0] ir_sh_reg;
	logic [3:0] ir_reg;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ir_sh_reg <= `DBGP_IR_CAPTURE;
			ir_reg <= `DBGP_IR_DEFAULT;
		end
		else if (state_reg == ST_RESET)
			ir_reg <= `DBGP_IR_DEFAULT;
		else if (tck_rise)
		begin
			case (state_reg)
				ST_CAP_IR:   ir_sh_reg <= `DBGP_IR_CAPTURE; // [R10]
				ST_SHIFT_IR: ir_sh_reg <= {tdi_s, ir_sh_reg[3:1]}; // [R7] [R9]
				ST_UPD_IR:   ir_reg <= ir_sh_reg; // [R11]
				default:     ir_sh_reg <= ir_sh_reg;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// data register path
	// ----------------------------------------------------------------
	// private codes open only when debug is allowed, else one-bit stage
	function automatic logic [`DBGP_LEN_W-1:0] dr_len(logic [3:0] ir,
		logic ok);
		if (!ok)
			dr_len = `DBGP_LEN_ONE;
		else
			case (ir)
				`DBGP_IR_CPU:  dr_len = `DBGP_LEN_CPU; // [R20]
				`DBGP_IR_BRK:  dr_len = `DBGP_LEN_BRK;
				`DBGP_IR_CTL:  dr_len = `DBGP_LEN_CTL;
				`DBGP_IR_COMM: dr_len = `DBGP_LEN_COMM;
				default:       dr_len = `DBGP_LEN_ONE;
			endcase
	endfunction

	function automatic logic [`DBGP_DR_W-1:0] shift_in(
		logic [`DBGP_DR_W-1:0] sh, logic [`DBGP_LEN_W-1:0] len, logic b);
		logic [`DBGP_DR_W-1:0] s;
		s = sh >> 1;
		s[len - `DBGP_LEN_W'(1)] = b;
		shift_in = s;
	endfunction

	logic [`DBGP_LEN_W-1:0] len;
	logic [3:0]             dr_sel;
	assign len    = dr_len(ir_reg, debug_ok);
	assign dr_sel = (len == `DBGP_LEN_ONE) ? `DBGP_IR_DEFAULT : ir_reg;

	logic [`DBGP_DR_W-1:0] dr_sh_reg;
	logic [INSN_W-1:0]     insn_reg;
	logic                  insn_pend_reg;
	dbgp_bp_cfg_t          bp_cfg_reg;
	logic                  halt_reg;
	logic                  brk_flag_reg;
	logic [7:0]            comm_reg;
	logic                  comm_dirty_reg;
	logic                  upd_ctl, upd_comm_cap, brk_event;

	assign upd_ctl = tck_rise && state_reg == ST_UPD_DR
		&& dr_sel == `DBGP_IR_CTL;
	assign upd_comm_cap = tck_rise && state_reg == ST_CAP_DR
		&& dr_sel == `DBGP_IR_COMM;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dr_sh_reg <= '0;
		else if (tck_rise && state_reg == ST_CAP_DR)
		begin
			case (dr_sel) // [R13]
				`DBGP_IR_CPU:  dr_sh_reg <= `DBGP_DR_W'(insn_reg);
				`DBGP_IR_BRK:  dr_sh_reg <= bp_cfg_reg;
				`DBGP_IR_CTL:  dr_sh_reg <= `DBGP_DR_W'({insn_pend_reg,
					halt_reg, brk_flag_reg});
				`DBGP_IR_COMM: dr_sh_reg <= `DBGP_DR_W'({comm_dirty_reg,
					comm_reg}); // [R17]
				default:       dr_sh_reg <= '0;
			endcase
		end
		else if (tck_rise && state_reg == ST_SHIFT_DR)
			dr_sh_reg <= shift_in(dr_sh_reg, len, tdi_s); // [R7]
	end

	// cpu instruction chain: loaded in update-dr, issued in idle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			insn_reg <= '0;
			insn_pend_reg <= 1'h0;
			cpu_insn <= '0;
			cpu_insn_valid <= 1'h0;
		end
		else
		begin
			cpu_insn_valid <= 1'h0;
			if (!debug_ok)
				insn_pend_reg <= 1'h0;
			else if (tck_rise && state_reg == ST_UPD_DR
				&& dr_sel == `DBGP_IR_CPU)
			begin
				insn_reg <= dr_sh_reg[INSN_W-1:0]; // [R14]
				insn_pend_reg <= 1'h1;
			end
			else if (insn_pend_reg && state_reg == ST_IDLE)
			begin
				cpu_insn <= insn_reg; // [R16] [R17]
				cpu_insn_valid <= 1'h1;
				insn_pend_reg <= 1'h0;
			end
		end
	end

	// breakpoint configuration chain
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			bp_cfg_reg <= '0;
		else if (tck_rise && state_reg == ST_UPD_DR
			&& dr_sel == `DBGP_IR_BRK)
			bp_cfg_reg <= dr_sh_reg; // [R14]
	end

	// ----------------------------------------------------------------
	// breakpoint unit
	// ----------------------------------------------------------------
	// bp2/bp3 match program or data; in mask mode bp3 masks bp2
	logic hit0, hit1, hit2, hit3, hit_rng, a2, a3;
	logic [15:0] addr2, addr3;
	assign addr2 = bp_cfg_reg.bp2_data ? cpu_obs.daddr : cpu_obs.pc;
	assign addr3 = bp_cfg_reg.bp3_data ? cpu_obs.daddr : cpu_obs.pc;
	assign a2 = bp_cfg_reg.bp2_data ? cpu_obs.daccess : cpu_obs.fetch;
	assign a3 = bp_cfg_reg.bp3_data ? cpu_obs.daccess : cpu_obs.fetch;
	assign hit0 = bp_cfg_reg.en[0] && cpu_obs.fetch
		&& cpu_obs.pc == bp_cfg_reg.bp0;
	assign hit1 = bp_cfg_reg.en[1] && cpu_obs.fetch
		&& cpu_obs.pc == bp_cfg_reg.bp1;
	assign hit2 = bp_cfg_reg.en[2] && a2 && !bp_cfg_reg.mask_mode
		&& addr2 == bp_cfg_reg.bp2;
	assign hit3 = bp_cfg_reg.en[3] && a3 && !bp_cfg_reg.mask_mode
		&& addr3 == bp_cfg_reg.bp3;
	assign hit_rng = bp_cfg_reg.en[2] && a2 && bp_cfg_reg.mask_mode
		&& (addr2 & bp_cfg_reg.bp3) == (bp_cfg_reg.bp2 & bp_cfg_reg.bp3);
	assign brk_event = debug_ok && (hit0 || hit1 || hit2 || hit3 || hit_rng
		|| (bp_cfg_reg.flow && cpu_obs.flow_change)
		|| (bp_cfg_reg.step && cpu_obs.step_done)); // [R18]

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			brk_flag_reg <= 1'h0;
			halt_reg <= 1'h0;
		end
		else
		begin
			// a new break wins over a clear in the same cycle
			if (brk_event)
				brk_flag_reg <= 1'h1;
			else if (upd_ctl && dr_sh_reg[`DBGP_CTL_CLRBRK])
				brk_flag_reg <= 1'h0;
			if (!debug_ok)
				halt_reg <= 1'h0;
			else if (upd_ctl)
				halt_reg <= dr_sh_reg[`DBGP_CTL_HALT]; // [R14]
		end
	end

	// ----------------------------------------------------------------
	// tdo and pin control
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			tdo_o <= 1'h0;
			tdo_oe <= 1'h0;
			tap_pullup_en <= 1'h0;
			tap_pins_gpio <= 1'h1;
			cpu_halt_req <= 1'h0;
			break_hit <= 1'h0;
		end
		else
		begin
			tap_pullup_en <= port_en; // [R3]
			tap_pins_gpio <= ~sync2_reg[3]; // [R2]
			cpu_halt_req <= halt_reg | brk_flag_reg;
			break_hit <= brk_flag_reg;
			if (!port_en)
				tdo_oe <= 1'h0;
			else if (tck_fall) // [R22]
			begin
				case (state_reg)
					ST_SHIFT_IR:
					begin
						tdo_o <= ir_sh_reg[0]; // [R10]
						tdo_oe <= 1'h1;
					end
					ST_SHIFT_DR:
					begin
						tdo_o <= dr_sh_reg[0]; // [R13]
						tdo_oe <= 1'h1;
					end
					default:
						tdo_oe <= 1'h0; // [R4]
				endcase
			end
		end
	end

	// ----------------------------------------------------------------
	// apb slave
	// ----------------------------------------------------------------
	logic apb_wr;
	assign apb_wr = psel & penable & pready & pwrite;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'h0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'h0;
		end
		else
		begin
			pready <= psel & ~penable;
			pslverr <= psel & ~penable & paddr != `DBGP_OFS_CTRL
				& paddr != `DBGP_OFS_STATUS & paddr != `DBGP_OFS_COMM;
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite)
			begin
				case (paddr)
					`DBGP_OFS_CTRL:   prdata <= 32'(ctrl_disable_reg);
					`DBGP_OFS_STATUS: prdata <= 32'({brk_flag_reg,
						debug_ok, port_en, ir_reg, state_reg});
					`DBGP_OFS_COMM:   prdata <= 32'({comm_dirty_reg,
						comm_reg[6:0]});
					default:          prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ctrl_disable_reg <= `DBGP_CTRL_RST;
			comm_reg <= 8'h00;
			comm_dirty_reg <= 1'h0;
		end
		else
		begin
			if (apb_wr && paddr == `DBGP_OFS_CTRL)
				ctrl_disable_reg <= pwdata[0];
			// cpu write sets dirty and wins over a debugger capture
			if (apb_wr && paddr == `DBGP_OFS_COMM)
			begin
				comm_reg <= pwdata[7:0]; // [R17]
				comm_dirty_reg <= 1'h1;
			end
			else if (upd_comm_cap)
				comm_dirty_reg <= 1'h0;
		end
	end

endmodule

`default_nettype wire

// [dbgp_consts.svh]
// constants of the debug test access port
`ifndef DBGP_CONSTS_SVH
`define DBGP_CONSTS_SVH

// register byte offsets
`define DBGP_OFS_CTRL    8'h00
`define DBGP_OFS_STATUS  8'h04
`define DBGP_OFS_COMM    8'h08
`define DBGP_CTRL_RST    1'h0

// instruction codes
`define DBGP_IR_W        4
`define DBGP_IR_CAPTURE  4'h1
`define DBGP_IR_DEFAULT  4'hF
`define DBGP_IR_CPU      4'h8
`define DBGP_IR_BRK      4'h9
`define DBGP_IR_CTL      4'hA
`define DBGP_IR_COMM     4'hB

// data register lengths
`define DBGP_DR_W        73
`define DBGP_LEN_W       7
`define DBGP_LEN_CPU     7'h10
`define DBGP_LEN_BRK     7'h49
`define DBGP_LEN_CTL     7'h08
`define DBGP_LEN_COMM    7'h09
`define DBGP_LEN_ONE     7'h01

// debug control field positions
`define DBGP_CTL_HALT    0
`define DBGP_CTL_CLRBRK  1

`endif

// [dbgp_pkg.sv]
// types of the debug test access port
package dbgp_pkg;

	typedef enum logic [3:0] {
		ST_RESET, ST_IDLE, ST_SEL_DR, ST_CAP_DR, ST_SHIFT_DR, ST_EXIT1_DR,
		ST_PAUSE_DR, ST_EXIT2_DR, ST_UPD_DR, ST_SEL_IR, ST_CAP_IR,
		ST_SHIFT_IR, ST_EXIT1_IR, ST_PAUSE_IR, ST_EXIT2_IR, ST_UPD_IR
	} dbgp_state_t;

	// breakpoint configuration, bp0 in the low bits
	typedef struct packed {
		logic        mask_mode;
		logic        bp3_data;
		logic        bp2_data;
		logic [3:0]  en;
		logic        step;
		logic        flow;
		logic [15:0] bp3;
		logic [15:0] bp2;
		logic [15:0] bp1;
		logic [15:0] bp0;
	} dbgp_bp_cfg_t;

	// what the cpu shows to the breakpoint unit
	typedef struct packed {
		logic [15:0] pc;
		logic        fetch;
		logic [15:0] daddr;
		logic        daccess;
		logic        flow_change;
		logic        step_done;
	} dbgp_cpu_obs_t;

endpackage

// [dbgp_tap_port_assertions.sv]
// concurrent checks on the ports of the debug test access port
`timescale 1ns/1ps
`default_nettype none
module dbgp_chk
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic tck_pin,
	input wire logic tdo_o,
	input wire logic tdo_oe,
	input wire logic tap_pullup_en,
	input wire logic tap_pins_gpio,
	input wire logic debug_port_enable_fuse,
	input wire logic onchip_debug_enable_fuse,
	input wire logic lock_bit_set,
	input wire logic cpu_insn_valid
);
	// ------
	// checks
	// ------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	property p_pready;
		psel && !penable |=> pready;
	endproperty
	a_pready: assert property (p_pready)
		else $error("no answer after setup");
	property p_gpio;
		!debug_port_enable_fuse [*4] |=> tap_pins_gpio;
	endproperty
	a_gpio: assert property (p_gpio)
		else $error("pins not general purpose");
	property p_excl;
		tap_pins_gpio |-> !tap_pullup_en;
	endproperty
	a_excl: assert property (p_excl)
		else $error("pull-up on while port off");
	property p_gpio_oe;
		tap_pins_gpio |-> !tdo_oe;
	endproperty
	a_gpio_oe: assert property (p_gpio_oe)
		else $error("tdo driven while port off");
	property p_tdo_fall;
		tdo_oe && $changed(tdo_o) |-> !tck_pin;
	endproperty
	a_tdo_fall: assert property (p_tdo_fall)
		else $error("tdo moved while tck high");
	property p_oe_fall;
		$changed(tdo_oe) |-> !tck_pin;
	endproperty
	a_oe_fall: assert property (p_oe_fall)
		else $error("tdo enable moved while tck high");
	property p_pulse;
		$rose(cpu_insn_valid) |=> !cpu_insn_valid;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("instruction strobe too long");
	property p_insn_ok;
		cpu_insn_valid |-> onchip_debug_enable_fuse && !lock_bit_set;
	endproperty
	a_insn_ok: assert property (p_insn_ok)
		else $error("instruction issued while debug off");
	c_insn: cover property (cpu_insn_valid);
	c_oe: cover property ($rose(tdo_oe));
	c_apb: cover property (psel && penable && pready);
endmodule
`default_nettype wire

// [dbgp_jtag_host.sv]
// model of the external test controller on the tap pins
`timescale 1ns/1ps
`default_nettype none
module dbgp_jtag_host
(
	input  wire logic pclk,
	input  wire logic tdo_o,
	input  wire logic tdo_oe,
	output var  logic tck_pin,
	output var  logic tms_pin,
	output var  logic tdi_pin
);
	logic tdo_w;
	// released tdo reads as the pull-up level
	assign tdo_w = tdo_oe ? tdo_o : 1'b1;
	initial
	begin
		tck_pin = 1'b0;
		tms_pin = 1'b1;
		tdi_pin = 1'b1;
	end
	// one tck period of 20 pclk; tdo taken just before the rise
	task automatic step(input logic m, input logic d, output logic q);
		tms_pin <= m;
		tdi_pin <= d;
		repeat (10) @(posedge pclk);
		q = tdo_w;
		tck_pin <= 1'b1;
		repeat (10) @(posedge pclk);
		tck_pin <= 1'b0;
	endtask
	// tms sequence, bit 0 first
	task automatic walk(input logic [7:0] t, input int n);
		logic q;
		for (int i = 0; i < n; i++)
			step(t[i], 1'b1, q);
	endtask
	// n bits lsb first, tms high with the last one
	task automatic shift(input int n, input logic [15:0] d,
		output logic [15:0] q);
		q = 16'h0;
		for (int i = 0; i < n; i++)
			step(i == n - 1, d[i], q[i]);
	endtask
endmodule
`default_nettype wire

// [dbgp_tap_port_tb_top.sv]
// testbench of the debug test access port
`timescale 1ns/1ps
`default_nettype none
module dbgp_tap_port_tb_top;
	import dbgp_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata, r;
	logic          tck_pin, tms_pin, tdi_pin, tdo_o, tdo_oe, e;
	logic          tap_pullup_en, tap_pins_gpio, lock_bit_set;
	logic          debug_port_enable_fuse, onchip_debug_enable_fuse;
	logic          cpu_insn_valid, cpu_halt_req, break_hit;
	logic [15:0]   cpu_insn, last_insn, q;
	dbgp_cpu_obs_t cpu_obs;
	int            err_total, checked, n_insn;
	dbgp_tap_port #(.INSN_W(16)) dbgp_tap_port_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.tck_pin, .tms_pin, .tdi_pin, .tdo_o, .tdo_oe, .tap_pullup_en,
		.tap_pins_gpio, .debug_port_enable_fuse, .onchip_debug_enable_fuse,
		.lock_bit_set, .cpu_obs, .cpu_insn, .cpu_insn_valid, .cpu_halt_req,
		.break_hit);
	dbgp_jtag_host dbgp_jtag_host_i (.pclk, .tdo_o, .tdo_oe, .tck_pin,
		.tms_pin, .tdi_pin);
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	always @(posedge pclk)
		if (cpu_insn_valid === 1'b1)
		begin
			n_insn <= n_insn + 1;
			last_insn <= cpu_insn;
		end
	// -------------
	// shared tasks
	// -------------
	task automatic complete_run();
		$display("checked %0d err_total %0d", checked, err_total);
		if (err_total == 0 && checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string s, input logic [31:0] x,
		input logic [31:0] v);
		checked++;
		if (v !== x)
		begin
			$display("FAIL %s expected %h seen %h", s, x, v);
			err_total++;
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		for (int n = 0; n < 20 && pready !== 1'b1; n++)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'h1, {31'h0, pready});
		if (pready !== 1'b1)
			complete_run();
	endtask
	task automatic ir(input logic [3:0] c);
		dbgp_jtag_host_i.walk(8'h03, 4);
		dbgp_jtag_host_i.shift(4, {12'h0, c}, q);
		chk("ir capture", 32'h1, {28'h0, q[3:0]});
		dbgp_jtag_host_i.walk(8'h01, 2);
		chk("tdo released", 32'h0, {31'h0, tdo_oe});
	endtask
	task automatic dr(input int n, input logic [15:0] d);
		dbgp_jtag_host_i.walk(8'h01, 3);
		dbgp_jtag_host_i.shift(n, d, q);
		dbgp_jtag_host_i.walk(8'h01, 2);
	endtask
	// ---------
	// scenarios
	// ---------
	task automatic s_fuse();
		repeat (6) @(posedge pclk);
		chk("gpio", 32'h1, {31'h0, tap_pins_gpio});
		dbgp_jtag_host_i.walk(8'h00, 2);
		apb(1'b0, 8'h04, 32'h0);
		chk("held state", 32'h0, {28'h0, r[3:0]});
		debug_port_enable_fuse <= 1'b1;
		repeat (6) @(posedge pclk);
		chk("pullup", 32'h1, {31'h0, tap_pullup_en});
		apb(1'b0, 8'h04, 32'h0);
		chk("reset state", 32'h0, {28'h0, r[3:0]});
	endtask
	task automatic s_ir();
		dbgp_jtag_host_i.walk(8'h00, 1);
		for (int c = 8; c < 12; c++)
		begin
			ir(c[3:0]);
			apb(1'b0, 8'h04, 32'h0);
			chk("ir state", {24'h0, c[3:0], 4'h1}, {24'h0, r[7:0]});
		end
	endtask
	task automatic s_ctl();
		ir(4'hA);
		dr(8, 16'h0001);
		chk("ctl capture", 32'h0, {24'h0, q[7:0]});
		chk("halt", 32'h1, {31'h0, cpu_halt_req});
		dr(8, 16'h0000);
		chk("ctl capture", 32'h2, {24'h0, q[7:0]});
		chk("halt", 32'h0, {31'h0, cpu_halt_req});
	endtask
	task automatic s_cpu();
		ir(4'h8);
		dr(16, 16'hA5C3);
		chk("insn", 32'hA5C3, {16'h0, last_insn});
		chk("insn count", 32'h1, n_insn);
		dr(16, 16'h0000);
		chk("insn capture", 32'hA5C3, {16'h0, q});
		lock_bit_set <= 1'b1;
		repeat (6) @(posedge pclk);
		ir(4'h8);
		dr(16, 16'h1234);
		chk("one bit stage", 32'h2468, {16'h0, q});
		chk("insn count", 32'h2, n_insn);
		lock_bit_set <= 1'b0;
	endtask
	// cpu byte reaches the debugger; a capture clears dirty
	task automatic s_comm();
		apb(1'b1, 8'h08, 32'h0000_0035);
		apb(1'b0, 8'h08, 32'h0);
		chk("comm dirty", 32'hB5, r);
		ir(4'hB);
		dr(9, 16'h0000);
		chk("comm capture", 32'h135, {23'h0, q[8:0]});
		apb(1'b0, 8'h08, 32'h0);
		chk("comm clean", 32'h35, r);
	endtask
	// 16 bits into the 73-bit chain: bit 7 lands on the flow enable
	task automatic s_brk();
		ir(4'h9);
		dr(16, 16'h0080);
		chk("bp capture", 32'h0, {16'h0, q});
		@(posedge pclk);
		cpu_obs.flow_change <= 1'b1;
		@(posedge pclk);
		cpu_obs.flow_change <= 1'b0;
		repeat (3) @(posedge pclk);
		chk("break", 32'h3, {30'h0, break_hit, cpu_halt_req});
		ir(4'hA);
		dr(8, 16'h0002);
		chk("ctl break", 32'h1, {24'h0, q[7:0]});
		chk("break clear", 32'h0, {30'h0, break_hit, cpu_halt_req});
	endtask
	task automatic s_reset();
		dbgp_jtag_host_i.walk(8'h01, 3);
		dbgp_jtag_host_i.walk(8'h1F, 5);
		apb(1'b0, 8'h04, 32'h0);
		chk("five high", 32'hF0, {24'h0, r[7:0]});
		dbgp_jtag_host_i.walk(8'h00, 1);
		apb(1'b1, 8'h00, 32'h1);
		dbgp_jtag_host_i.walk(8'h00, 1);
		apb(1'b0, 8'h04, 32'h0);
		chk("disabled", 32'hF0, {23'h0, r[8:0]});
		chk("pullup", 32'h0, {31'h0, tap_pullup_en});
		chk("tdo off", 32'h0, {31'h0, tdo_oe});
		apb(1'b1, 8'h00, 32'h0);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h1, {31'h0, e});
		dbgp_jtag_host_i.walk(8'h00, 1);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, 8'h04, 32'h0);
		chk("mapped", 32'h0, {31'h0, e});
		chk("reset again", 32'hF0, {24'h0, r[7:0]});
	endtask
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		debug_port_enable_fuse = 1'b0;
		onchip_debug_enable_fuse = 1'b1;
		lock_bit_set = 1'b0;
		cpu_obs = '0;
		err_total = 0;
		checked = 0;
		n_insn = 0;
		last_insn = 16'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		s_fuse();
		s_ir();
		s_ctl();
		s_cpu();
		s_comm();
		s_brk();
		s_reset();
		complete_run();
	end
endmodule
bind dbgp_tap_port dbgp_chk dbgp_chk_i (.pclk, .presetn, .psel, .penable,
	.pready, .tck_pin, .tdo_o, .tdo_oe, .tap_pullup_en, .tap_pins_gpio,
	.debug_port_enable_fuse, .onchip_debug_enable_fuse, .lock_bit_set,
	.cpu_insn_valid);
`default_nettype wire
